// *** hdl/lcdtc_frame_div.sv ***
// frame divider: one frame pulse every divisor oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module lcdtc_frame_div #(
   parameter int W = 12
) (
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   input  wire logic         tick,
   input  wire logic [W-1:0] divisor,
   output logic              frame_tick
);
   logic [W-1:0] cnt;
   logic         last;

   // >= so a smaller divisor taken mid-frame ends the frame at once
   assign last = (cnt >= divisor - W'(1));

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cnt <= '0;
      end else if (tick) begin
         cnt <= last ? '0 : cnt + W'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         frame_tick <= 1'b0;
      end else begin
         frame_tick <= tick & last;
      end
   end
endmodule : lcdtc_frame_div
`default_nettype wire

// *** hdl/lcdtc_osc_tick.sv ***
// oscillator tick source: internal rc divider or synchronised external clock
`timescale 1ns/1ps
`default_nettype none
module lcdtc_osc_tick
   import lcdtc_pkg::*;
#(
   parameter int RC_DIV = RC_DIV_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic run,
   input  wire logic ext_mode,
   input  wire logic osc_pin_in,
   output logic      tick
);
   logic       ext_s1;
   logic       ext_s2;
   logic       ext_s3;
   logic [7:0] rc_cnt;
   logic       rc_wrap;

   assign rc_wrap = (rc_cnt == 8'(RC_DIV - 1));

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
      end else begin
         ext_s1 <= osc_pin_in;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b || !run || ext_mode) begin
         rc_cnt <= 8'h00;
      end else if (rc_wrap) begin
         rc_cnt <= 8'h00;
      end else begin
         rc_cnt <= rc_cnt + 8'h01;
      end
   end

   // a stopped source gives no ticks, so execution and frame timing freeze with it
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tick <= 1'b0;
      end else begin
         tick <= run & (ext_mode ? (ext_s2 & ~ext_s3) : rc_wrap);
      end
   end
endmodule : lcdtc_osc_tick
`default_nettype wire

// *** hdl/lcdtc_top.sv ***
// display-technique instruction interpreter with apb register access
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module lcdtc_top
   import lcdtc_pkg::*;
#(
   parameter int ADDR_W         = 8,
   parameter int NORMAL_EXEC_NS = 27000,
   parameter int SUPER_EXEC_NS  = 54000,
   parameter int RC_DIV         = RC_DIV_CYCLES
) (
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              osc_pin_in,
   input  wire logic              key_scan_in,
   output logic                   duty_select,
   output logic                   shared_pin_is_common,
   output logic                   drive_level4,
   output logic                   osc_rc_mode,
   output logic                   osc_running,
   output logic                   frame_tick,
   output logic                   busy,
   output logic                   ram_write_pulse,
   output logic      [1:0]        ram_write_target,
   output logic                   ram_format_super
);
   localparam logic [7:0] NORMAL_TICKS = exec_ticks(NORMAL_EXEC_NS);
   localparam logic [7:0] SUPER_TICKS  = exec_ticks(SUPER_EXEC_NS);

   lcdtc_cfg_s   cfg;
   lcdtc_state_e state;
   logic         configured;
   logic [7:0]   exec_left;
   logic [9:0]   last_cmd;
   logic         err_busy;
   logic         err_order;
   logic         key_s1;
   logic         key_s2;
   logic         osc_tick;
   logic [11:0]  frame_divisor;

   logic         apb_acc;
   logic         hit_cmd;
   logic         hit_cfg;
   logic         hit_stat;
   logic         cmd_wr;
   logic [7:0]   code;
   logic [1:0]   kind;
   logic         is_ram;
   logic         is_tech;
   logic         is_onoff;
   logic         super_fmt;
   logic         order_ok;
   logic         accept;
   logic         next_sleep;
   logic [7:0]   next_ticks;
   logic [31:0]  next_rdata;

   // ---------------- apb slave ----------------
   assign apb_acc  = psel & penable;
   assign hit_cmd  = (paddr == ADDR_W'(OFS_CMD));
   assign hit_cfg  = (paddr == ADDR_W'(OFS_CFG));
   assign hit_stat = (paddr == ADDR_W'(OFS_STAT));
   assign pready   = 1'b1;
   assign pslverr  = apb_acc & ~(hit_cmd | hit_cfg | hit_stat);

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (hit_cmd) begin
         next_rdata[9:0] = last_cmd;
      end else if (hit_cfg) begin
         next_rdata[5:0] = {configured, cfg};
      end else if (hit_stat) begin
         next_rdata[STAT_BUSY]      = busy;
         next_rdata[STAT_ERR_BUSY]  = err_busy;
         next_rdata[STAT_ERR_ORDER] = err_order;
      end
   end

   // read data is captured in the setup cycle so it comes from a flop with zero wait
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_rdata;
      end
   end

   // ---------------- instruction decode ----------------
   assign cmd_wr    = apb_acc & pwrite & hit_cmd;
   assign code      = pwdata[7:0];
   assign kind      = pwdata[KIND_LSB+1:KIND_LSB];
   assign is_ram    = (kind != KIND_GEN);
   assign is_tech   = !is_ram && (code[7:4] == OP_TECH);
   assign is_onoff  = !is_ram && (code[7:4] == OP_ONOFF);
   assign super_fmt = code[CODE_INC_SUPER] & ~code[CODE_INC_NORMAL];

   // before setup only setup is taken; in sleep setup and ram writes need normal mode
   always_comb begin
      if (!configured) begin
         order_ok = is_tech;
      end else if (cfg.sleep) begin
         order_ok = !is_tech && !is_ram;
      end else begin
         order_ok = 1'b1;
      end
   end

   assign accept     = cmd_wr && (state == ST_IDLE) && order_ok;
   assign next_sleep = is_onoff ? code[CODE_SLEEP] : cfg.sleep;

   always_comb begin
      if (!configured) begin
         next_ticks = FIRST_EXEC_TICKS;
      end else if (next_sleep) begin
         next_ticks = SLEEP_EXEC_TICKS;
      end else if (is_ram && super_fmt) begin
         next_ticks = SUPER_TICKS;
      end else begin
         next_ticks = NORMAL_TICKS;
      end
   end

   // ---------------- configuration ----------------
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cfg        <= CFG_RST;
         configured <= 1'b0;
      end else if (accept && is_tech) begin
         cfg.duty            <= code[CODE_DUTY];
         cfg.frame_rate_bit0 <= code[CODE_RATE_B0];
         cfg.frame_rate_bit1 <= code[CODE_RATE_B1];
         cfg.clk_src         <= code[CODE_CLK_SRC];
         configured          <= 1'b1;
      end else if (accept && is_onoff) begin
         cfg.sleep <= code[CODE_SLEEP];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         last_cmd <= 10'h000;
      end else if (accept) begin
         last_cmd <= pwdata[9:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ram_write_pulse  <= 1'b0;
         ram_write_target <= KIND_GEN;
         ram_format_super <= 1'b0;
      end else begin
         ram_write_pulse <= accept & is_ram;
         if (accept && is_ram) begin
            ram_write_target <= kind;
            ram_format_super <= super_fmt;
         end
      end
   end

   // ---------------- execution timer ----------------
   // counted in oscillator ticks, so every time stretches with a slower clock
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state     <= ST_IDLE;
         exec_left <= 8'h00;
      end else begin
         case (state)
            ST_IDLE: begin
               if (accept) begin
                  state     <= ST_EXEC;
                  exec_left <= next_ticks;
               end
            end
            ST_EXEC: begin
               if (osc_tick) begin
                  exec_left <= exec_left - 8'h01;
                  if (exec_left == 8'h01) begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state     <= ST_IDLE;
               exec_left <= 8'h00;
            end
         endcase
      end
   end

   assign busy = (state == ST_EXEC);

   // sticky errors, write one to clear; a new event in the clearing cycle wins
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         err_busy  <= 1'b0;
         err_order <= 1'b0;
      end else begin
         err_busy  <= (cmd_wr & busy)
                    | (err_busy & ~(apb_acc & pwrite & hit_stat & pwdata[STAT_ERR_BUSY]));
         err_order <= (cmd_wr & ~busy & ~order_ok)
                    | (err_order & ~(apb_acc & pwrite & hit_stat & pwdata[STAT_ERR_ORDER]));
      end
   end

   // ---------------- clock source and frame ----------------
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         key_s1 <= 1'b0;
         key_s2 <= 1'b0;
      end else begin
         key_s1 <= key_scan_in;
         key_s2 <= key_s1;
      end
   end

   // the source also runs while an instruction executes, else a sleep command never ends
   assign osc_running          = ~cfg.sleep | key_s2 | busy;
   assign drive_level4         = cfg.sleep;
   assign duty_select          = cfg.duty;
   assign shared_pin_is_common = cfg.duty;
   assign osc_rc_mode          = ~cfg.clk_src;
   assign frame_divisor        = frame_div(cfg.duty, cfg.frame_rate_bit0,
                                           cfg.frame_rate_bit1);

   lcdtc_osc_tick #(
      .RC_DIV (RC_DIV)
   ) u_osc (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .run        (osc_running),
      .ext_mode   (cfg.clk_src),
      .osc_pin_in (osc_pin_in),
      .tick       (osc_tick)
   );

   lcdtc_frame_div #(
      .W (12)
   ) u_frame (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .tick       (osc_tick),
      .divisor    (frame_divisor),
      .frame_tick (frame_tick)
   );

   // ---------------- checks ----------------
   logic [7:0] ticks_seen;
   logic       exec_first;
   logic       exec_sleep;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ticks_seen <= 8'h00;
         exec_first <= 1'b0;
         exec_sleep <= 1'b0;
      end else if (accept) begin
         ticks_seen <= 8'h00;
         exec_first <= !configured;
         exec_sleep <= next_sleep;
      end else if (busy && osc_tick) begin
         ticks_seen <= ticks_seen + 8'h01;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_tech_acc;
      accept && is_tech;
   endsequence

   property p_first_time;
      $fell(busy) && exec_first |-> ticks_seen == 8'd33;
   endproperty
   a_first_time: assert property (p_first_time) else $error("first setup time wrong");

   property p_sleep_time;
      $fell(busy) && exec_sleep && !exec_first |-> ticks_seen == 8'd9;
   endproperty
   a_sleep_time: assert property (p_sleep_time) else $error("sleep exec time wrong");

   property p_scale;
      busy && !osc_tick |=> exec_left == $past(exec_left);
   endproperty
   a_scale: assert property (p_scale) else $error("timer moved without a tick");

   property p_order;
      cmd_wr && !configured && !is_tech |=> err_order && !busy;
   endproperty
   a_order: assert property (p_order) else $error("command before setup taken");

   property p_decode;
      s_tech_acc |=> configured && cfg.duty == $past(pwdata[CODE_DUTY])
                     && cfg.frame_rate_bit0 == $past(pwdata[CODE_RATE_B0]) && busy;
   endproperty
   a_decode: assert property (p_decode) else $error("setup fields not taken");

   property p_div8;
      s_tech_acc ##0 (pwdata[2:1] == 2'b10) ##0 !pwdata[CODE_DUTY]
         |=> !duty_select && frame_divisor == DIV8_FAST;
   endproperty
   a_div8: assert property (p_div8) else $error("1/8 duty divisor wrong");

   property p_div9;
      s_tech_acc ##0 (pwdata[2:1] == 2'b01) ##0 pwdata[CODE_DUTY] |=> frame_divisor == DIV9_MID;
   endproperty
   a_div9: assert property (p_div9) else $error("1/9 duty divisor wrong");

   property p_fc11;
      s_tech_acc ##0 (pwdata[2:1] == 2'b11) |=> frame_divisor inside {DIV8_SLOW, DIV9_SLOW};
   endproperty
   a_fc11: assert property (p_fc11) else $error("frame bits 11 not slowest");

   property p_shared;
      s_tech_acc ##0 pwdata[CODE_DUTY] |=> shared_pin_is_common && !$stable(state);
   endproperty
   a_shared: assert property (p_shared) else $error("shared pin not common");

   property p_ext_clk;
      s_tech_acc ##0 pwdata[CODE_CLK_SRC] |=> !osc_rc_mode;
   endproperty
   a_ext_clk: assert property (p_ext_clk) else $error("external clock not selected");

   property p_sleep_stop;
      drive_level4 && !busy && !key_s2 |-> !osc_running ##1 !osc_tick;
   endproperty
   a_sleep_stop: assert property (p_sleep_stop) else $error("clock runs in sleep");

   property p_super;
      accept && is_ram && super_fmt |=> ram_format_super && ram_write_pulse;
   endproperty
   a_super: assert property (p_super) else $error("super format not flagged");

endmodule : lcdtc_top
`default_nettype wire

// *** include/lcdtc_pkg.sv ***
// package: constants, types and helpers for the display-technique interpreter
package lcdtc_pkg;

   localparam logic [7:0] OFS_CMD  = 8'h00;
   localparam logic [7:0] OFS_CFG  = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;

   localparam int CODE_DUTY       = 0;
   localparam int CODE_RATE_B0    = 1;
   localparam int CODE_RATE_B1    = 2;
   localparam int CODE_CLK_SRC    = 3;
   localparam int CODE_SLEEP      = 3;
   localparam int CODE_INC_NORMAL = 0;
   localparam int CODE_INC_SUPER  = 1;
   localparam int KIND_LSB        = 8;

   localparam int STAT_BUSY      = 0;
   localparam int STAT_ERR_BUSY  = 1;
   localparam int STAT_ERR_ORDER = 2;

   localparam logic [3:0] OP_TECH  = 4'h8;
   localparam logic [3:0] OP_ONOFF = 4'h4;

   localparam logic [1:0] KIND_GEN  = 2'h0;
   localparam logic [1:0] KIND_CHAR = 2'h1;
   localparam logic [1:0] KIND_ACC  = 2'h2;

   localparam logic [4:0] CFG_RST = 5'h00;

   localparam int CLK_PERIOD_NS = 25;
   localparam int REF_FREQ_KHZ  = 300;
   localparam int FIRST_EXEC_NS = 108000;
   localparam int SLEEP_EXEC_NS = 27000;
   localparam int RC_DIV_CYCLES = (1000000 / REF_FREQ_KHZ) / CLK_PERIOD_NS;

   localparam logic [11:0] DIV8_SLOW = 12'hc00;
   localparam logic [11:0] DIV8_MID  = 12'h600;
   localparam logic [11:0] DIV8_FAST = 12'h300;
   localparam logic [11:0] DIV9_SLOW = 12'hd80;
   localparam logic [11:0] DIV9_MID  = 12'h6c0;
   localparam logic [11:0] DIV9_FAST = 12'h360;

   typedef struct packed {
      logic sleep;
      logic clk_src;
      logic frame_rate_bit1;
      logic frame_rate_bit0;
      logic duty;
   } lcdtc_cfg_s;

   typedef enum logic {ST_IDLE, ST_EXEC} lcdtc_state_e;

   // least time in oscillator ticks, rounded up
   function automatic logic [7:0] exec_ticks(input int ns);
      int t;
      t = (ns * REF_FREQ_KHZ + 999999) / 1000000;
      return t[7:0];
   endfunction : exec_ticks

   function automatic logic [11:0] frame_div(input logic duty, input logic rate0, input logic rate1);
      logic [11:0] d;
      case ({rate0, rate1})
         2'b10:   d = duty ? DIV9_MID : DIV8_MID;
         2'b01:   d = duty ? DIV9_FAST : DIV8_FAST;
         default: d = duty ? DIV9_SLOW : DIV8_SLOW;
      endcase
      return d;
   endfunction : frame_div

   localparam logic [7:0] FIRST_EXEC_TICKS = exec_ticks(FIRST_EXEC_NS);
   localparam logic [7:0] SLEEP_EXEC_TICKS = exec_ticks(SLEEP_EXEC_NS);

endpackage : lcdtc_pkg

// *** verif/lcd_display_technique_config_test.sv ***
// self-checking bench for the display-technique interpreter
`timescale 1ns/1ps
`default_nettype none
module lcd_display_technique_config_test import lcdtc_pkg::*; ;
   localparam int DIV = 2;
   logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        osc_pin_in, key_scan_in, duty_select, shared_pin_is_common;
   logic        drive_level4, osc_rc_mode, osc_running, frame_tick, busy;
   logic        ram_write_pulse, ram_format_super, ext_run, err;
   logic [1:0]  ram_write_target;
   logic [7:0]  ext_half, code;
   logic [3:0]  snap;
   int          err_total, total_checks, n;
   int          lows[$] = '{4, 2, 6, 1, 3, 5};

   lcdtc_top #(.RC_DIV(DIV)) lcdtc_top_inst (
      .core_clk(core_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .osc_pin_in(osc_pin_in),
      .key_scan_in(key_scan_in), .duty_select(duty_select),
      .shared_pin_is_common(shared_pin_is_common), .drive_level4(drive_level4),
      .osc_rc_mode(osc_rc_mode), .osc_running(osc_running), .frame_tick(frame_tick),
      .busy(busy), .ram_write_pulse(ram_write_pulse),
      .ram_write_target(ram_write_target), .ram_format_super(ram_format_super));
   lcdtc_ext_clk_model lcdtc_ext_clk_model_inst (
      .core_clk(core_clk), .run(ext_run), .half(ext_half), .osc_pin(osc_pin_in));

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : chk

   task automatic chk_rng(input int v, input int mid, input int slack);
      chk((v >= mid - slack && v <= mid + slack) ? mid : v, mid);
   endtask : chk_rng

   task automatic bail(input int k, input int lim);
      if (k >= lim) begin
         err_total++;
         summarize();
      end
   endtask : bail

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      bail(k, 50);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // counts busy cycles; ticks of zero skips the timing compare
   task automatic run(input logic [1:0] kind, input logic [7:0] c, input int ticks,
                      input int per, input int slack);
      apb(1'b1, OFS_CMD, {22'h0, kind, c});
      #1;
      snap = {ram_write_pulse, ram_write_target, ram_format_super};
      chk(busy, 1'b1);
      n = 0;
      while (busy === 1'b1 && n < 5000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      bail(n, 5000);
      if (ticks > 0) chk_rng(n, ticks * per, slack);
   endtask : run

   task automatic wait_frame();
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (frame_tick !== 1'b1 && n < 20000);
      bail(n, 20000);
   endtask : wait_frame

   function automatic int tk(input int ns);
      return (ns * 300 + 999999) / 1000000;
   endfunction : tk

   function automatic int fdiv(input int lo);
      int b;
      b = lo[0] ? 3456 : 3072;
      if (lo[2:1] == 2'b01) b = b / 2;
      if (lo[2:1] == 2'b10) b = b / 4;
      return b;
   endfunction : fdiv

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
      {key_scan_in, ext_run} = 2'b00;
      ext_half = 8'h05;
      err_total = 0;
      total_checks = 0;
      void'($urandom(60410));
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      #1;
      chk({busy, duty_select, drive_level4, osc_rc_mode}, 4'b0001);
      apb(1'b1, OFS_CMD, 32'h23);
      #1;
      chk(busy, 1'b0);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd[2], 1'b1);
      apb(1'b1, OFS_STAT, 32'h4);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd[2:0], 3'h0);
      $display("test order done");
      run(2'h0, 8'h82, tk(108000), DIV, DIV + 2);
      chk({duty_select, shared_pin_is_common, osc_rc_mode}, 3'b001);
      $display("test first setup done");
      foreach (lows[i]) begin
         run(2'h0, {4'h8, 4'(lows[i])}, 9, DIV, DIV + 2);
         apb(1'b0, OFS_CFG, 32'h0);
         chk(rd[5:0], 6'h20 | 6'(lows[i]));
         chk({duty_select, shared_pin_is_common}, {2{lows[i][0]}});
         wait_frame();
         wait_frame();
         wait_frame();
         chk(n, fdiv(lows[i]) * DIV);
      end
      $display("test frame rate done");
      for (int i = 0; i < 3; i++) begin
         code = {4'(($urandom % 3) + 1), 4'($urandom)};
         run(2'h0, code, 9, DIV, DIV + 2);
      end
      apb(1'b1, OFS_CMD, 32'h15);
      apb(1'b1, OFS_CMD, 32'h16);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd[1:0], 2'b11);
      repeat (30) @(posedge core_clk);
      apb(1'b0, OFS_CMD, 32'h0);
      chk(rd[9:0], 10'h015);
      apb(1'b1, OFS_STAT, 32'h2);
      $display("test busy refusal done");
      run(2'h1, 8'h02, tk(54000), DIV, DIV + 2);
      chk(snap, 4'b1011);
      run(2'h2, 8'h01, 9, DIV, DIV + 2);
      chk(snap, 4'b1100);
      run(2'h2, 8'h02, tk(54000), DIV, DIV + 2);
      chk(snap, 4'b1101);
      $display("test ram write done");
      ext_run <= 1'b1;
      run(2'h0, 8'h88, 9, 10, 14);
      chk(osc_rc_mode, 1'b0);
      ext_half <= 8'h0a;
      run(2'h0, 8'h88, 9, 20, 24);
      run(2'h0, 8'h80, 0, 1, 0);
      ext_run <= 1'b0;
      chk(osc_rc_mode, 1'b1);
      $display("test external clock done");
      run(2'h0, 8'h48, tk(27000), DIV, DIV + 2);
      chk({drive_level4, osc_running}, 2'b10);
      apb(1'b1, OFS_CMD, 32'h101);
      #1;
      chk(busy, 1'b0);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd[2], 1'b1);
      apb(1'b0, OFS_CFG, 32'h0);
      chk(rd[4], 1'b1);
      key_scan_in <= 1'b1;
      repeat (5) @(posedge core_clk);
      #1;
      chk(osc_running, 1'b1);
      key_scan_in <= 1'b0;
      repeat (5) @(posedge core_clk);
      #1;
      chk(osc_running, 1'b0);
      run(2'h0, 8'h40, 9, DIV, DIV + 2);
      chk({drive_level4, osc_running}, 2'b01);
      $display("test sleep done");
      apb(1'b0, 8'h0c, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      apb(1'b1, 8'h10, 32'h5);
      chk(err, 1'b1);
      $display("test unmapped done");
      run(2'h0, 8'h85, 9, DIV, DIV + 2);
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      #1;
      chk({busy, duty_select, drive_level4, osc_rc_mode}, 4'b0001);
      apb(1'b1, OFS_CMD, 32'h40);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd[2:0], 3'h4);
      apb(1'b0, OFS_CFG, 32'h0);
      chk(rd[5:0], 6'h00);
      $display("test reset again done");
      summarize();
   end
endmodule : lcd_display_technique_config_test
`default_nettype wire

// *** verif/lcdtc_ext_clk_model.sv ***
// host-side external clock source on the oscillator pin
`timescale 1ns/1ps
`default_nettype none
module lcdtc_ext_clk_model (
   input  wire logic       core_clk,
   input  wire logic       run,
   input  wire logic [7:0] half,
   output logic            osc_pin
);
   logic [7:0] cnt;
   // a stopped host clock rests low rather than holding a stale phase
   always @(posedge core_clk) begin
      if (!run) begin
         osc_pin <= 1'b0;
         cnt     <= 8'h00;
      end else if (cnt + 8'h01 >= half) begin
         osc_pin <= ~osc_pin;
         cnt     <= 8'h00;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule : lcdtc_ext_clk_model
`default_nettype wire
